//--- logic/ndc_pkg.sv
// package: constants, types and field layout for the data nonvolatile access block
package ndc_pkg;
  // memory geometry
  localparam int unsigned NDC_ADDR_W    = 8;
  localparam int unsigned NDC_DATA_W    = 8;
  localparam int unsigned NDC_DEPTH     = 256;
  // control register field positions
  localparam int unsigned NDC_BIT_PGM   = 7;  // program_memory_select
  localparam int unsigned NDC_BIT_CFG   = 6;  // config_space_select
  localparam int unsigned NDC_BIT_WEN   = 2;  // write_enable
  localparam int unsigned NDC_BIT_WR    = 1;  // write request / busy
  localparam int unsigned NDC_BIT_RD    = 0;  // read request
  // unlock key bytes
  localparam logic [7:0]  NDC_KEY1      = 8'h55;
  localparam logic [7:0]  NDC_KEY2      = 8'hAA;
  // reset values
  localparam logic [7:0]  NDC_CTRL_RST  = 8'h00;
  localparam logic [7:0]  NDC_ADDR_RST  = 8'h00;
  localparam logic [7:0]  NDC_DATA_RST  = 8'h00;
  // self-timed write duration
  localparam int unsigned NDC_WRITE_US  = 4;
  localparam int unsigned NDC_CLK_MHZ   = 250;
  localparam int unsigned NDC_WRITE_CYC = NDC_WRITE_US * NDC_CLK_MHZ;
  localparam int unsigned NDC_CNT_W     = 16;
  // unlock progress
  typedef enum logic [1:0] {NDC_LK_IDLE, NDC_LK_KEY1, NDC_LK_ARMED} ndc_lock_t;
  // software write strobes with data
  typedef struct packed {
    logic       addr_we;   // write the address register
    logic       data_we;   // write the data register
    logic       ctrl_we;   // write the control register
    logic       unlock_we; // write the unlock register
    logic [7:0] wdata;     // byte written
  } ndc_sw_t;
endpackage

//--- logic/ndc_mem.sv
// byte memory with registered read data
`timescale 1ns/100ps
module ndc_mem (
  input  wire logic                          i_mclk,
  input  wire logic                          i_we,
  input  wire logic [ndc_pkg::NDC_ADDR_W-1:0] i_waddr,
  input  wire logic [ndc_pkg::NDC_DATA_W-1:0] i_wdata,
  input  wire logic                          i_re,
  input  wire logic [ndc_pkg::NDC_ADDR_W-1:0] i_raddr,
  output logic      [ndc_pkg::NDC_DATA_W-1:0] o_rdata
);
  import ndc_pkg::*;
  // storage array, contents undefined at power-up
  logic [NDC_DATA_W-1:0] mem_reg [NDC_DEPTH];

  // write port
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  // registered read port
  always_ff @(posedge i_mclk) begin
    if (i_re) begin
      o_rdata <= mem_reg[i_raddr];
    end
  end
endmodule // ndc_mem

//--- logic/ndc_ctrl.sv
// access control for the on-chip data nonvolatile byte memory
//
// Contract
// - read byte ready for next instruction
// - data holds until next read or write
// - write needs 55h, AAh, then write bit
// - write bit refused unless write enable set
// - write enable and write together start nothing
// - hardware never clears write enable
// - registers frozen while write runs
// - completion clears write bit, sets flag
// - hardware never clears complete flag
//
// timing notes
// - each readback output lags its internal register by one clock
// - a read lands in the data register one clock after its strobe is taken
// - a write holds the busy bit for WRITE_CYC clocks; the memory takes
//   the byte and the complete flag rises as the last of them ends
// - a key byte of 55h always restarts the unlock order, so a doubled
//   first key does not lock software out
// - reads and writes share the address register
// - the complete flag is lowered only by i_flag_clr
`timescale 1ns/100ps
module ndc_ctrl #(
  parameter int unsigned WRITE_CYC = ndc_pkg::NDC_WRITE_CYC  // write duration in cycles
) (
  input  wire logic            i_mclk,
  input  wire logic            i_rst,
  input  wire ndc_pkg::ndc_sw_t i_sw,                  // software register writes
  input  wire logic            i_flag_clr,             // software clears the complete flag
  output logic      [7:0]      o_nvm_address_reg,      // address register readback
  output logic      [7:0]      o_nvm_data_reg,         // data register readback
  output logic      [7:0]      o_nvm_control_reg,      // control register readback
  output logic                 o_write_complete_flag   // sticky write-done flag
);
  import ndc_pkg::*;

  logic [7:0]           addr_reg;   // address register
  logic [7:0]           data_reg;   // data register
  logic                 pgm_reg;    // program_memory_select
  logic                 cfg_reg;    // config_space_select
  logic                 wen_reg;    // write_enable
  logic                 wr_reg;     // write busy
  logic                 rd_pend;    // read captured, data lands next cycle
  logic                 flag_reg;   // write complete flag
  ndc_lock_t            lock_reg;   // unlock progress
  logic [NDC_CNT_W-1:0] cnt_reg;    // write timer
  logic [7:0]           mem_rdata;  // memory read data
  logic                 rd_go;      // read request accepted
  logic                 wr_go;      // write start accepted
  logic                 wr_done;    // timer expiry
  logic                 data_space; // data memory selected

  // data memory is selected when both select bits are clear
  assign data_space = !pgm_reg && !cfg_reg;

  assign rd_go = i_sw.ctrl_we && i_sw.wdata[NDC_BIT_RD] && !wr_reg
                 && !i_sw.wdata[NDC_BIT_PGM] && !i_sw.wdata[NDC_BIT_CFG];

  assign wr_go = i_sw.ctrl_we && i_sw.wdata[NDC_BIT_WR] && !wr_reg && wen_reg
                 && (lock_reg == NDC_LK_ARMED) && data_space;

  assign wr_done = wr_reg && (cnt_reg == NDC_CNT_W'(WRITE_CYC - 1));

  // memory, written at the end of the timed cycle
  // both ports use the address register, which is frozen while busy
  ndc_mem u_mem (
    .i_mclk  (i_mclk),
    .i_we    (wr_done),
    .i_waddr (addr_reg),
    .i_wdata (data_reg),
    .i_re    (rd_go),
    .i_raddr (addr_reg),
    .o_rdata (mem_rdata)
  );

  // address register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      addr_reg <= NDC_ADDR_RST;
    end else if (i_sw.addr_we && !wr_reg) begin
      addr_reg <= i_sw.wdata;
    end
  end

  // read pending marker
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= rd_go;
    end
  end

  // data register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      data_reg <= NDC_DATA_RST;
    // load read byte
    // a read issued with the write-start strobe is dropped to keep the byte
    end else if (rd_pend && !wr_reg) begin
      data_reg <= mem_rdata;
    end else if (i_sw.data_we && !wr_reg) begin
      data_reg <= i_sw.wdata;
    end
  end

  // control bits written by software
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pgm_reg <= NDC_CTRL_RST[NDC_BIT_PGM];
      cfg_reg <= NDC_CTRL_RST[NDC_BIT_CFG];
      wen_reg <= NDC_CTRL_RST[NDC_BIT_WEN];
    end else if (i_sw.ctrl_we && !wr_reg) begin
      pgm_reg <= i_sw.wdata[NDC_BIT_PGM];
      cfg_reg <= i_sw.wdata[NDC_BIT_CFG];
      // wr_go reads the enable held before this write
      wen_reg <= i_sw.wdata[NDC_BIT_WEN];
    end
  end

  // unlock sequencer: any other register write breaks the order
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lock_reg <= NDC_LK_IDLE;
    end else begin
      case (lock_reg)
        NDC_LK_IDLE: begin
          if (i_sw.unlock_we && i_sw.wdata == NDC_KEY1) begin
            // first key seen
            lock_reg <= NDC_LK_KEY1;
          end
        end
        NDC_LK_KEY1: begin
          if (i_sw.unlock_we && i_sw.wdata == NDC_KEY2) begin
            // second key completes the unlock
            lock_reg <= NDC_LK_ARMED;
          end else if (i_sw.unlock_we && i_sw.wdata == NDC_KEY1) begin
            // repeated first key keeps waiting for the second
            lock_reg <= NDC_LK_KEY1;
          end else if (i_sw.unlock_we || i_sw.addr_we || i_sw.data_we || i_sw.ctrl_we) begin
            // wrong key or any other register write breaks the order
            lock_reg <= NDC_LK_IDLE;
          end
        end
        NDC_LK_ARMED: begin
          // consumed by the next register write of any kind
          if (i_sw.unlock_we && i_sw.wdata == NDC_KEY1) begin
            // a fresh first key starts a new sequence
            lock_reg <= NDC_LK_KEY1;
          end else if (i_sw.unlock_we || i_sw.addr_we || i_sw.data_we || i_sw.ctrl_we) begin
            lock_reg <= NDC_LK_IDLE;
          end
        end
        default: begin
          lock_reg <= NDC_LK_IDLE;
        end
      endcase
    end
  end

  // write busy bit and timer
  // the timer runs 0 to WRITE_CYC-1; the last count ends the write
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_reg  <= 1'b0;
      cnt_reg <= '0;
    end else if (wr_go) begin
      wr_reg  <= 1'b1;
      cnt_reg <= '0;
    end else if (wr_done) begin
      wr_reg  <= 1'b0;
      cnt_reg <= '0;
    end else if (wr_reg) begin
      cnt_reg <= cnt_reg + NDC_CNT_W'(1);
    end
  end

  // sticky completion flag, set wins over clear
  // a clear in the completion clock is lost, software must clear again
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      flag_reg <= 1'b0;
    end else if (wr_done) begin
      flag_reg <= 1'b1;
    end else if (i_flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // registered readback outputs
  // control byte: selects, enable and busy; the read request reads as 0
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_nvm_address_reg     <= NDC_ADDR_RST;
      o_nvm_data_reg        <= NDC_DATA_RST;
      o_nvm_control_reg     <= NDC_CTRL_RST;
      o_write_complete_flag <= 1'b0;
    end else begin
      o_nvm_address_reg     <= addr_reg;
      o_nvm_data_reg        <= data_reg;
      o_nvm_control_reg     <= {pgm_reg, cfg_reg, 3'h0, wen_reg, wr_reg, 1'b0};
      o_write_complete_flag <= flag_reg;
    end
  end
endmodule // ndc_ctrl

//--- sim/ndc_ctrl_checker.sv
// checker: port timing relations of the nvm access control
`timescale 1ns/100ps
module ndc_ctrl_checker #(
  parameter int unsigned WRITE_CYC = ndc_pkg::NDC_WRITE_CYC  // write duration in cycles
) (
  input wire logic             i_mclk,
  input wire logic             i_rst,
  input wire ndc_pkg::ndc_sw_t i_sw,
  input wire logic             i_flag_clr,
  input wire logic [7:0]       o_nvm_address_reg,
  input wire logic [7:0]       o_nvm_data_reg,
  input wire logic [7:0]       o_nvm_control_reg,
  input wire logic             o_write_complete_flag
);
  import ndc_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire logic bsy = o_nvm_control_reg[NDC_BIT_WR];   // write busy
  wire logic wen = o_nvm_control_reg[NDC_BIT_WEN];  // write enable
  wire logic sel = |o_nvm_control_reg[7:6];         // a non-data space selected
  wire logic flg = o_write_complete_flag;           // done flag
  int unsigned bsy_run;                             // busy clocks seen in this write
  // counts the clocks in which the busy bit is seen high
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bsy_run <= '0;
    end else if (bsy) begin
      bsy_run <= bsy_run + 32'h1;
    end else begin
      bsy_run <= '0;
    end
  end
  // two keys then the write bit, back to back
  sequence key_s;
    i_sw.unlock_we && i_sw.wdata == NDC_KEY1 ##1
    i_sw.unlock_we && i_sw.wdata == NDC_KEY2 ##1 i_sw.ctrl_we && i_sw.wdata[NDC_BIT_WR];
  endsequence
  wen_hold_a: assert property ($changed(wen) |-> $past(i_sw.ctrl_we, 2))
    else $error("write enable moved on its own");
  flag_hold_a: assert property ($fell(flg) |-> $past(i_flag_clr, 2))
    else $error("done flag cleared on its own");
  regs_frozen_a: assert property (bsy && $past(bsy) |-> $stable(o_nvm_address_reg)
    && $stable(o_nvm_data_reg) && $stable(o_nvm_control_reg[7:6]) && $stable(wen))
    else $error("register moved while busy");
  write_start_a: assert property (key_s ##0 (wen && !bsy && !sel) |-> ##2 bsy)
    else $error("unlocked write did not start");
  write_cause_a: assert property ($rose(bsy) |-> $past(i_sw.ctrl_we, 2) && $past(wen, 2)
    && $past(i_sw.unlock_we, 3) && $past(i_sw.wdata, 3) == NDC_KEY2
    && $past(i_sw.unlock_we, 4) && $past(i_sw.wdata, 4) == NDC_KEY1)
    else $error("write started without unlock");
  busy_len_a: assert property ($fell(bsy) |-> bsy_run == WRITE_CYC)
    else $error("write duration wrong");
  busy_cap_a: assert property (bsy_run <= WRITE_CYC)
    else $error("write ran too long");
  done_flag_a: assert property ($fell(bsy) |-> flg)
    else $error("done without flag");
  flag_cause_a: assert property ($rose(flg) |-> $fell(bsy))
    else $error("flag set without done");
  data_hold_a: assert property ($changed(o_nvm_data_reg) |-> $past(i_sw.data_we, 2)
    || ($past(i_sw.ctrl_we, 3) && $past(i_sw.wdata[NDC_BIT_RD], 3)))
    else $error("data register moved on its own");
endmodule // ndc_ctrl_checker
bind ndc_ctrl ndc_ctrl_checker #(.WRITE_CYC(WRITE_CYC)) u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_sw(i_sw), .i_flag_clr(i_flag_clr), .o_nvm_address_reg(o_nvm_address_reg),
  .o_nvm_data_reg(o_nvm_data_reg), .o_nvm_control_reg(o_nvm_control_reg),
  .o_write_complete_flag(o_write_complete_flag));

//--- sim/ndc_ctrl_tb.sv
// testbench: random and corner write and read sequences
`timescale 1ns/100ps
module ndc_ctrl_tb;
  import ndc_pkg::*;
  localparam int unsigned WC = 4;  // shortened write duration
  logic       i_mclk = 1'b0;
  logic       i_rst = 1'b1;
  ndc_sw_t    i_sw = '0;
  logic       i_flag_clr = 1'b0;
  logic [7:0] o_a, o_d, o_c;
  logic       o_f;
  int         err_total = 0;
  int         compares = 0;
  int         seed = 52;
  logic [7:0] a, d;
  logic [7:0] mem_m [256];  // expected memory
  bit         ok_m [256];   // address written
  ndc_ctrl #(.WRITE_CYC(WC)) i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sw(i_sw),
    .i_flag_clr(i_flag_clr), .o_nvm_address_reg(o_a), .o_nvm_data_reg(o_d),
    .o_nvm_control_reg(o_c), .o_write_complete_flag(o_f));
  // clock
  always #2 i_mclk = ~i_mclk;
  // expected control byte from the enable and program-select bits
  function automatic logic [7:0] ctl(input logic w, input logic p);
    return (8'(w) << NDC_BIT_WEN) | (8'(p) << NDC_BIT_PGM);
  endfunction
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // one register write: 1 addr, 2 data, 3 ctrl, 4 unlock, 0 none
  task sw(input int k, input logic [7:0] b);
    @(posedge i_mclk);
    i_sw <= {k == 1, k == 2, k == 3, k == 4, b};
  endtask
  task idle(input int n);
    repeat (n) sw(0, 8'h00);
  endtask
  // write attempt: 0 good, 1 no keys, 2 broken order, 3 enable with write, 4 program space
  task tryw(input int m);
    sw(1, a);
    sw(2, d);
    sw(3, m == 3 ? 8'h00 : (m == 4 ? 8'h84 : 8'h04));
    if (m != 1) sw(4, NDC_KEY1);
    if (m == 2) sw(2, d);
    if (m != 1) sw(4, NDC_KEY2);
    sw(3, m == 4 ? 8'h86 : 8'h06);
    sw(0, 8'h00);
    sw(1, ~a);
    sw(2, ~d);
    idle(1);
    #1;
    chk("busy", o_c, ctl(1'b1, m == 4) | (8'(m == 0) << NDC_BIT_WR));
    idle(WC + 3);
    #1;
    chk("flag", {7'h00, o_f}, {7'h00, m == 0});
    chk("ctrl", o_c, ctl(1'b1, m == 4));
    chk("addr", o_a, m == 0 ? a : ~a);
    chk("data", o_d, m == 0 ? d : ~d);
    if (m == 0) mem_m[a] = d;
    if (m == 0) ok_m[a] = 1'b1;
    @(posedge i_mclk);
    i_flag_clr <= 1'b1;
    @(posedge i_mclk);
    i_flag_clr <= 1'b0;
    sw(2, ~d);
    sw(1, a);
    idle(3);
    #1;
    chk("flag", {7'h00, o_f}, 8'h00);
    chk("data", o_d, ~d);
    sw(3, m == 4 ? 8'h81 : 8'h01);
    idle(4);
    #1;
    chk("ctrl", o_c, ctl(1'b0, m == 4));
    if (m == 4) chk("data", o_d, ~d);
    else if (ok_m[a]) chk("read", o_d, mem_m[a]);
  endtask
  task report_and_stop;
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    chk("ctrl", o_c, NDC_CTRL_RST);
    chk("addr", o_a, NDC_ADDR_RST);
    chk("data", o_d, NDC_DATA_RST);
    for (int i = 0; i < 20; i++) begin
      a = (i == 0) ? 8'hFF : 8'($random(seed));
      d = 8'($random(seed));
      tryw(i < 5 ? i : {$random(seed)} % 5);
    end
    report_and_stop;
  end
  // watchdog
  initial begin
    #20000;
    err_total++;
    report_and_stop;
  end
endmodule // ndc_ctrl_tb
